// *** hpr_pkg.sv ***
package hpr_pkg;
   // access type codes on access_type_select
   localparam logic [1:0] ACC_CONTROL = 2'h0;
   localparam logic [1:0] ACC_DATA_AUTOINC = 2'h1;
   localparam logic [1:0] ACC_ADDRESS = 2'h2;
   localparam logic [1:0] ACC_DATA_FIXED = 2'h3;
   // halfword select values
   localparam logic HALF_FIRST = 1'b0;
   localparam logic HALF_SECOND = 1'b1;
   // reset values
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [15:0] HALF_RESET = 16'h0000;
   // data valid ahead of ready, in cpu periods
   localparam int DATA_LEAD_PERIODS = 1;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DATA_LEAD_NS = DATA_LEAD_PERIODS * CLK_PERIOD_NS;
   localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // port state machine, gray coded along the usual path except store back to idle
   typedef enum logic [2:0] {
      HPR_IDLE = 3'h0,
      HPR_FETCH = 3'h1,
      HPR_LEAD = 3'h3,
      HPR_ACTIVE = 3'h2,
      HPR_STORE = 3'h6
   } hpr_state_t;
endpackage : hpr_pkg

// *** hpr_host_port.sv ***
`timescale 1ns/100ps
// Contract
// - internal strobe is low only when chip select is low and the two data strobes differ.
// - ready is forced low whenever chip select is high.
// - chip select falling while a data transfer is still running shows busy until it ends.
// - first halfword of a data read requests a dma word and stays busy until it is loaded.
// - after the second halfword of a data write or autoincrement read, busy while stored.
// - other accesses end with ready low and no busy period.
// - control and address register accesses never touch ready.
// - read data is valid on the bus one cpu period before ready goes low.
// - the bus is driven only after the strobe falls and released after it rises.
// - during reset ready is high if chip select is low and low if chip select is high.
module hpr_host_port #(
   parameter int ADDR_W = 32
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic port_chip_select_n,
   input wire logic data_strobe_a,
   input wire logic data_strobe_b,
   input wire logic address_strobe_n,
   input wire logic [1:0] access_type_select,
   input wire logic read_not_write,
   input wire logic halfword_select,
   input wire logic [15:0] port_data_in,
   output logic [15:0] port_data_out,
   output logic port_data_oe,
   output logic port_ready_n,
   output logic dma_req,
   output logic dma_write,
   output logic [31:0] dma_wdata,
   input wire logic dma_done,
   input wire logic [31:0] dma_rdata,
   output logic [ADDR_W-1:0] port_address_register,
   output logic [31:0] port_control_register
);
   import hpr_pkg::*;

   initial begin
      if (ADDR_W < 1 || ADDR_W > 32) $error("ADDR_W must be 1..32");
   end

   // pin synchronisers; first stage feeds only the second
   logic [23:0] pin_s1_reg;
   logic [23:0] pin_s2_reg;
   logic [23:0] pin_raw;
   assign pin_raw = {port_chip_select_n, data_strobe_a, data_strobe_b, address_strobe_n,
      access_type_select, read_not_write, halfword_select, port_data_in};
   // kept out of reset so ready can follow chip select while in reset
   always_ff @(posedge mclk) begin
      if (clk_en) begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   logic cs_n_s;
   logic strobe_n;
   logic as_n_s;
   logic [1:0] acc_s;
   logic rnw_s;
   logic half_s;
   logic [15:0] din_s;
   assign cs_n_s = pin_s2_reg[23];
   // composite strobe, not(a xor b) or cs
   assign strobe_n = ~(pin_s2_reg[22] ^ pin_s2_reg[21]) | cs_n_s;
   assign as_n_s = pin_s2_reg[20];
   assign acc_s = pin_s2_reg[19:18];
   assign rnw_s = pin_s2_reg[17];
   assign half_s = pin_s2_reg[16];
   assign din_s = pin_s2_reg[15:0];

   // select signals latched at address strobe fall, else at strobe fall
   logic strobe_n_d_reg;
   logic as_n_d_reg;
   logic [3:0] sel_reg;
   logic [3:0] sel_next;
   logic strobe_fall;
   logic strobe_rise;
   assign strobe_fall = strobe_n_d_reg & ~strobe_n;
   assign strobe_rise = ~strobe_n_d_reg & strobe_n;

   // host data bits get one register stage more than the controls
   logic [15:0] din_reg;
   always_ff @(posedge mclk) begin
      if (srst) begin
         din_reg <= HALF_RESET;
      end else if (clk_en) begin
         din_reg <= din_s;
      end
   end

   always_comb begin
      sel_next = sel_reg;
      if (as_n_d_reg & ~as_n_s) begin
         sel_next = {acc_s, rnw_s, half_s};
      end else if (strobe_fall & as_n_s) begin
         sel_next = {acc_s, rnw_s, half_s};
      end
   end

   logic [1:0] acc_l;
   logic rnw_l;
   logic half_l;
   assign acc_l = sel_next[3:2];
   assign rnw_l = sel_next[1];
   assign half_l = sel_next[0];
   logic is_data;
   logic is_busy_kind;
   assign is_data = (acc_l == ACC_DATA_AUTOINC) || (acc_l == ACC_DATA_FIXED);
   // only data writes and autoincrement reads leave a transfer behind
   assign is_busy_kind = is_data && (!rnw_l || acc_l == ACC_DATA_AUTOINC);

   // main state
   hpr_state_t state_reg, state_next;
   logic busy_reg, busy_next;
   logic [31:0] data_reg, data_next;
   logic [15:0] dout_reg, dout_next;
   logic oe_reg, oe_next;
   logic req_reg, req_next;
   logic wr_reg, wr_next;
   logic pend_kind_reg, pend_kind_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [31:0] ctrl_reg, ctrl_next;

   always_comb begin
      state_next = state_reg;
      busy_next = busy_reg;
      data_next = data_reg;
      dout_next = dout_reg;
      oe_next = oe_reg;
      req_next = 1'b0;
      wr_next = wr_reg;
      pend_kind_next = pend_kind_reg;
      addr_next = addr_reg;
      ctrl_next = ctrl_reg;
      case (state_reg)
         HPR_IDLE: begin
            if (strobe_fall) begin
               if (is_data && rnw_l && half_l == HALF_FIRST) begin
                  req_next = 1'b1;
                  wr_next = 1'b0;
                  busy_next = 1'b1;
                  state_next = HPR_FETCH;
               end else begin
                  if (rnw_l) begin
                     // second halfword or register read, data already held
                     case (acc_l)
                        ACC_CONTROL: dout_next = half_l ? ctrl_reg[31:16] : ctrl_reg[15:0];
                        ACC_ADDRESS: dout_next = half_l ? 16'(32'(addr_reg) >> 16)
                           : 16'(addr_reg);
                        default: dout_next = half_l ? data_reg[31:16] : data_reg[15:0];
                     endcase
                     oe_next = 1'b1;
                  end
                  state_next = HPR_ACTIVE;
               end
            end
         end
         HPR_FETCH: begin
            if (dma_done) begin
               data_next = dma_rdata;
               dout_next = dma_rdata[15:0];
               oe_next = 1'b1;
               state_next = HPR_LEAD;
            end
         end
         HPR_LEAD: begin
            busy_next = 1'b0; // data stood one period before ready
            state_next = HPR_ACTIVE;
         end
         HPR_ACTIVE: begin
            if (strobe_rise) begin
               oe_next = 1'b0;
               state_next = HPR_IDLE;
               if (!rnw_l) begin
                  // assemble the word, first halfword low
                  case (acc_l)
                     ACC_CONTROL: ctrl_next = half_l ? {din_reg, ctrl_reg[15:0]}
                        : {ctrl_reg[31:16], din_reg};
                     ACC_ADDRESS: addr_next = half_l ? ADDR_W'({din_reg, 16'(addr_reg)})
                        : ADDR_W'({16'(32'(addr_reg) >> 16), din_reg});
                     default: data_next = half_l ? {din_reg, data_reg[15:0]}
                        : {data_reg[31:16], din_reg};
                  endcase
               end
               if (half_l == HALF_SECOND && is_busy_kind) begin
                  req_next = 1'b1;
                  wr_next = ~rnw_l;
                  busy_next = 1'b1;
                  // kind kept apart: an address strobe may relatch selects while busy
                  pend_kind_next = (acc_l == ACC_DATA_AUTOINC);
                  state_next = HPR_STORE;
               end
            end
         end
         HPR_STORE: begin
            if (dma_done) begin
               busy_next = 1'b0;
               if (pend_kind_reg) begin
                  addr_next = addr_reg + ADDR_W'(4);
               end
               state_next = HPR_IDLE;
            end
         end
         default: state_next = HPR_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= HPR_IDLE;
         busy_reg <= 1'b0;
         data_reg <= DATA_RESET;
         dout_reg <= HALF_RESET;
         oe_reg <= 1'b0;
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         pend_kind_reg <= 1'b0;
         addr_reg <= '0;
         ctrl_reg <= DATA_RESET;
         sel_reg <= 4'h0;
         strobe_n_d_reg <= 1'b1;
         as_n_d_reg <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
         busy_reg <= busy_next;
         data_reg <= data_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
         req_reg <= req_next;
         wr_reg <= wr_next;
         pend_kind_reg <= pend_kind_next;
         addr_reg <= addr_next;
         ctrl_reg <= ctrl_next;
         sel_reg <= sel_next;
         strobe_n_d_reg <= strobe_n;
         as_n_d_reg <= as_n_s;
      end
   end

   // ready gated by chip select; in reset busy while selected
   assign port_ready_n = ~cs_n_s & (srst | busy_reg);
   assign port_data_out = dout_reg;
   assign port_data_oe = oe_reg;
   assign dma_req = req_reg;
   assign dma_write = wr_reg;
   assign dma_wdata = data_reg;
   assign port_address_register = addr_reg;
   assign port_control_register = ctrl_reg;
endmodule : hpr_host_port

// *** hpr_host_port_sva.sv ***
`timescale 1ns/100ps
module hpr_host_sva (
   input wire logic mclk,
   input wire logic srst,
   input wire logic port_chip_select_n,
   input wire logic data_strobe_a,
   input wire logic data_strobe_b,
   input wire logic port_data_oe,
   input wire logic port_ready_n,
   input wire logic dma_req
);
   // composite strobe, low while selected and the data strobes differ
   wire logic strobe_n = port_chip_select_n | ~(data_strobe_a ^ data_strobe_b);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   cs_gate_a: assert property (port_chip_select_n [*3] |-> !port_ready_n)
      else $error("ready not low with chip select high");
   busy_sel_a: assert property ($rose(port_ready_n) |-> !port_chip_select_n)
      else $error("busy raised while not selected");
   req_pulse_a: assert property (dma_req |=> !dma_req)
      else $error("dma request longer than one cycle");
   data_lead_a: assert property ($rose(port_data_oe) && port_ready_n |=> !port_ready_n)
      else $error("ready not one period after read data");
   drive_after_a: assert property ($rose(port_data_oe) |-> !$past(strobe_n))
      else $error("bus driven without strobe");
   bus_release_a: assert property (strobe_n [*5] |-> !port_data_oe)
      else $error("bus still driven after strobe rise");
   rst_ready_a: assert property (disable iff (1'b0)
      (srst && !port_chip_select_n) [*3] |-> port_ready_n)
      else $error("ready not high in reset while selected");
   busy_bound_a: assert property (port_ready_n |-> ##[1:60] !port_ready_n)
      else $error("busy period too long");
endmodule : hpr_host_sva
bind hpr_host_port hpr_host_sva i_sva (.mclk(mclk), .srst(srst),
   .port_chip_select_n(port_chip_select_n), .data_strobe_a(data_strobe_a),
   .data_strobe_b(data_strobe_b), .port_data_oe(port_data_oe),
   .port_ready_n(port_ready_n), .dma_req(dma_req));

// *** hpr_host_model.sv ***
`timescale 1ns/100ps
module hpr_host_model (
   input wire logic mclk,
   input wire logic port_ready_n,
   input wire logic [15:0] port_data_out,
   input wire logic port_data_oe,
   output logic port_chip_select_n,
   output logic data_strobe_a,
   output logic data_strobe_b,
   output logic [1:0] access_type_select,
   output logic read_not_write,
   output logic halfword_select,
   output logic address_strobe_n,
   output logic [15:0] port_data_in
);
   logic [15:0] drv = 16'h0;
   logic use_as = 1'b0;
   // bus level: device when it drives, else host data or a toggling float
   assign port_data_in = port_data_oe ? port_data_out : drv;
   initial begin
      {port_chip_select_n, data_strobe_a, data_strobe_b} = 3'h0;
      {access_type_select, read_not_write, halfword_select} = 4'h0;
      address_strobe_n = 1'b1;
   end
   // one halfword; waits out a busy port before striking the strobe
   task automatic access(input logic [1:0] t, input logic rnw, input logic hw,
      input logic [15:0] wd, output logic [15:0] rd, output int busy);
      int n;
      n = 0;
      busy = 0;
      @(negedge mclk);
      {access_type_select, read_not_write, halfword_select} = {t, rnw, hw};
      drv = rnw ? ~drv : wd;
      port_chip_select_n = 1'b0;
      // optional address strobe falls a period after the selects settle
      if (use_as) begin
         @(negedge mclk);
         address_strobe_n = 1'b0;
      end
      repeat (3) @(negedge mclk);
      while (n < 300 && port_ready_n !== 1'b0) begin
         @(negedge mclk);
         n++;
         busy++;
      end
      data_strobe_a = 1'b1;
      n = 0;
      // low at least four periods and until ready, since strobes are synced
      while (n < 300 && !(n >= 4 && port_ready_n === 1'b0)) begin
         @(negedge mclk);
         n++;
         busy += int'(port_ready_n === 1'b1);
      end
      rd = port_data_out;
      {data_strobe_a, port_chip_select_n} = 2'h1;
      address_strobe_n = 1'b1;
      drv = ~drv;
      repeat (4) @(negedge mclk);
   endtask : access
endmodule : hpr_host_model

// *** hpr_host_port_tb_top.sv ***
`timescale 1ns/100ps
module hpr_host_port_tb_top;
   import hpr_pkg::*;
   logic mclk, srst = 1'b1, cs_n, ds_a, ds_b, rnw, hws, oe, rdy_n, dma_req, dma_write;
   logic dma_done = 1'b0;
   logic as_n;
   logic [1:0] ats;
   logic [15:0] pdi, pdo;
   logic [31:0] dma_wdata, dma_rdata = 32'h0, par, pcr, addr, w, ctl, r;
   logic [31:0] mem [logic [31:0]];
   int n_mismatch = 0, checks_done = 0, cyc = 0, lat = 0, b0, b1;
   integer seed = 32'h7e93c9c2;
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   hpr_host_port i_dut (.mclk(mclk), .srst(srst), .clk_en(1'b1), .port_chip_select_n(cs_n),
      .data_strobe_a(ds_a), .data_strobe_b(ds_b), .address_strobe_n(as_n),
      .access_type_select(ats), .read_not_write(rnw), .halfword_select(hws),
      .port_data_in(pdi), .port_data_out(pdo), .port_data_oe(oe), .port_ready_n(rdy_n),
      .dma_req(dma_req), .dma_write(dma_write), .dma_wdata(dma_wdata), .dma_done(dma_done),
      .dma_rdata(dma_rdata), .port_address_register(par), .port_control_register(pcr));
   hpr_host_model i_host (.mclk(mclk), .port_ready_n(rdy_n), .port_data_out(pdo),
      .port_data_oe(oe), .port_chip_select_n(cs_n), .data_strobe_a(ds_a),
      .data_strobe_b(ds_b), .access_type_select(ats), .read_not_write(rnw),
      .halfword_select(hws), .address_strobe_n(as_n), .port_data_in(pdi));
   // aux dma stand-in; slow enough that stores outlast the host's gap
   always @(negedge mclk) begin
      dma_done <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma_req === 1'b1) begin
         lat <= 8 + ($random(seed) & 7);
         if (dma_write === 1'b1) mem[par] = dma_wdata;
      end else if (lat > 1) lat <= lat - 1;
      else if (lat == 1) begin
         lat <= 0;
         dma_done <= 1'b1;
         dma_rdata <= mem.exists(par) ? mem[par] : ~par;
      end
   end
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic chk_busy(string what, bit exp, int busy);
      chk_val(what, {31'h0, exp}, {31'h0, busy != 0});
   endtask : chk_busy
   // a 32-bit access as low then high halfword
   task automatic word(input logic [1:0] t, input logic rd_n, input logic [31:0] wd);
      i_host.access(t, rd_n, HALF_FIRST, wd[15:0], r[15:0], b0);
      i_host.access(t, rd_n, HALF_SECOND, wd[31:16], r[31:16], b1);
   endtask : word
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (16) @(negedge mclk);
      chk_val("reset ready", 32'h1, {31'h0, rdy_n});
      srst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         // odd passes latch the selects on the address strobe
         i_host.use_as = i[0];
         addr = $random(seed) & 32'hffff_fffc;
         w = $random(seed);
         ctl = $random(seed);
         word(ACC_ADDRESS, 1'b0, addr);
         chk_val("address reg", addr, par);
         word(ACC_CONTROL, 1'b0, ctl);
         chk_val("control reg", ctl, pcr);
         chk_busy("control busy", 1'b0, b0 + b1);
         word(ACC_DATA_FIXED, 1'b0, w);
         chk_val("stored word", w, mem[addr]);
         word(ACC_ADDRESS, 1'b1, 32'h0);
         chk_val("address read", addr, r);
         chk_busy("store busy", 1'b1, b0);
         word(ACC_DATA_FIXED, 1'b1, 32'h0);
         chk_val("fixed read", w, r);
         chk_busy("fetch busy", 1'b1, b0);
         chk_busy("second half", 1'b0, b1);
         word(ACC_DATA_AUTOINC, 1'b1, 32'h0);
         chk_val("autoinc read", w, r);
         word(ACC_ADDRESS, 1'b1, 32'h0);
         chk_val("next address", addr + 32'h4, r);
         chk_busy("autoinc busy", 1'b1, b0);
      end
      report_and_stop();
   end
endmodule : hpr_host_port_tb_top
